//--- rtl/pel_top.sv
// PLL event interrupt latch: edge capture, sticky flags, suppress and combine logic
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module pel_top
    import pel_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire pel_bus_req_t bus_req_i,
    input wire pel_src_t src_i,
    output logic [7:0] rd_data_o,
    output logic irq_o,
    output logic [7:0] live_o
);

    // Place the four sources at their event bit positions
    function automatic logic [7:0] pel_place(input logic [3:0] s);
        logic [7:0] v;
        v = 8'h00;
        v[PEL_BIT_UNLOCKED] = s[3];
        v[PEL_BIT_MISSING] = s[2];
        v[PEL_BIT_VCO] = s[1];
        v[PEL_BIT_RETURN] = s[0];
        return v;
    endfunction : pel_place

    // Synchroniser stages; sources come from analog status logic
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [7:0] prev_reg;
    logic [7:0] suppress_reg;
    logic [7:0] edge_sel_reg;
    logic [7:0] event_reg;
    logic [7:0] control_reg;
    logic [7:0] rd_data_reg;
    logic irq_reg;

    logic [7:0] suppress_next;
    logic [7:0] edge_sel_next;
    logic [7:0] event_next;
    logic [7:0] control_next;
    logic [7:0] rd_data_next;
    logic irq_next;

    // Two-flop synchroniser; only stage two is read by logic
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            sync1_reg <= PEL_RST_SRC;
            sync2_reg <= PEL_RST_SRC;
        end else begin
            sync1_reg <= src_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Reference loss masks the unlock it causes
    wire logic [3:0] src_eff;
    wire logic [7:0] live_now;
    assign src_eff = {sync2_reg[3] & ~sync2_reg[2], sync2_reg[2:0]};
    assign live_now = pel_place(src_eff);

    // Edge detect against the value one clock earlier
    wire logic [7:0] rise;
    wire logic [7:0] fall;
    wire logic [7:0] hit;
    assign rise = live_now & ~prev_reg;
    assign fall = ~live_now & prev_reg;
    // Per bit: select one picks rising, zero picks falling
    assign hit = ((rise & edge_sel_reg) | (fall & ~edge_sel_reg)) & PEL_EVENT_BITS;

    // Previous-value register, also the live status seen by software
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            prev_reg <= PEL_RST_LIVE;
        end else begin
            prev_reg <= live_now;
        end
    end

    // Address decode
    wire logic wr_suppress;
    wire logic wr_edge_sel;
    wire logic wr_event;
    wire logic wr_control;
    assign wr_suppress = bus_req_i.wr && (bus_req_i.addr == PEL_OFS_SUPPRESS);
    assign wr_edge_sel = bus_req_i.wr && (bus_req_i.addr == PEL_OFS_EDGE_SEL);
    assign wr_event = bus_req_i.wr && (bus_req_i.addr == PEL_OFS_EVENT);
    assign wr_control = bus_req_i.wr && (bus_req_i.addr == PEL_OFS_CONTROL);

    wire logic int_en;
    wire logic and_mode;
    assign int_en = control_reg[PEL_CTL_ENABLE_BIT];
    assign and_mode = control_reg[PEL_CTL_AND_BIT];

    // Writing zero clears; writing one leaves a flag alone
    wire logic [7:0] clr;
    assign clr = wr_event ? (~bus_req_i.wdata & PEL_EVENT_BITS) : 8'h00;

    // Flag update: set wins over clear, frozen while disabled
    assign event_next = int_en ? (((event_reg & ~clr) | hit) & PEL_EVENT_BITS) : event_reg;

    // Configuration registers; suppress and edge select store reserved bits as written, control drops them
    assign suppress_next = wr_suppress ? bus_req_i.wdata : suppress_reg;
    assign edge_sel_next = wr_edge_sel ? bus_req_i.wdata : edge_sel_reg;
    assign control_next = wr_control ? (bus_req_i.wdata & PEL_CTL_BITS) : control_reg;

    // Interrupt combine over unsuppressed flags
    wire logic [7:0] active;
    wire logic [7:0] unsup;
    wire logic any_act;
    wire logic all_act;
    assign active = event_reg & ~suppress_reg & PEL_EVENT_BITS;
    assign unsup = ~suppress_reg & PEL_EVENT_BITS;
    assign any_act = |active;
    // All suppressed counts as nothing to signal, not as all true
    assign all_act = (unsup != 8'h00) && (active == unsup);
    assign irq_next = int_en && (and_mode ? all_act : any_act);

    // Read mux; unmapped addresses read zero
    wire logic [7:0] rd_mux;
    assign rd_mux = (bus_req_i.addr == PEL_OFS_LIVE) ? prev_reg :
                    (bus_req_i.addr == PEL_OFS_SUPPRESS) ? suppress_reg :
                    (bus_req_i.addr == PEL_OFS_EDGE_SEL) ? edge_sel_reg :
                    (bus_req_i.addr == PEL_OFS_EVENT) ? event_reg :
                    (bus_req_i.addr == PEL_OFS_CONTROL) ? control_reg : 8'h00;
    // Data stand only in the cycle after the strobe
    assign rd_data_next = bus_req_i.rd ? rd_mux : 8'h00;

    // Register bank
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            suppress_reg <= PEL_RST_SUPPRESS;
            edge_sel_reg <= PEL_RST_EDGE_SEL;
            event_reg <= PEL_RST_EVENT;
            control_reg <= PEL_RST_CONTROL;
        end else begin
            suppress_reg <= suppress_next;
            edge_sel_reg <= edge_sel_next;
            event_reg <= event_next;
            control_reg <= control_next;
        end
    end

    // Output flops
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rd_data_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            irq_reg <= irq_next;
        end
    end

    assign rd_data_o = rd_data_reg;
    assign irq_o = irq_reg;
    assign live_o = prev_reg;

    // Checks on the design's own state
    default clocking pel_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Rising unlock with rising select while enabled
    sequence unl_rise_s;
        !live_now[PEL_BIT_UNLOCKED] ##1 (live_now[PEL_BIT_UNLOCKED] && edge_sel_reg[PEL_BIT_UNLOCKED] && int_en);
    endsequence

    // Falling reference-missing with falling select while enabled
    sequence miss_fall_s;
        live_now[PEL_BIT_MISSING] ##1 (!live_now[PEL_BIT_MISSING] && !edge_sel_reg[PEL_BIT_MISSING] && int_en);
    endsequence

    unl_rise_set_a: assert property (unl_rise_s |=> event_reg[PEL_BIT_UNLOCKED])
        else $error("unlocked rising edge did not set its flag");

    miss_fall_set_a: assert property (miss_fall_s |=> event_reg[PEL_BIT_MISSING])
        else $error("missing falling edge did not set its flag");

    vco_wrong_edge_a: assert property ((edge_sel_reg[PEL_BIT_VCO] && fall[PEL_BIT_VCO]) |-> !hit[PEL_BIT_VCO])
        else $error("VCO falling edge hit while rising selected");

    ret_fall_edge_a: assert property ((!edge_sel_reg[PEL_BIT_RETURN] && rise[PEL_BIT_RETURN]) |-> !hit[PEL_BIT_RETURN])
        else $error("return rising edge hit while falling selected");

    flag_sticky_a: assert property ((event_reg[PEL_BIT_VCO] && !clr[PEL_BIT_VCO]) |=> event_reg[PEL_BIT_VCO])
        else $error("VCO flag dropped without a clear");

    flag_freeze_a: assert property (!int_en |=> (event_reg == $past(event_reg)))
        else $error("event flags changed while disabled");

    unl_clear_a: assert property ((int_en && clr[PEL_BIT_UNLOCKED] && !hit[PEL_BIT_UNLOCKED]) |=> !event_reg[PEL_BIT_UNLOCKED])
        else $error("unlocked flag not cleared by zero write");

    set_beats_clr_a: assert property ((int_en && hit[PEL_BIT_MISSING] && clr[PEL_BIT_MISSING]) |=> event_reg[PEL_BIT_MISSING])
        else $error("clear beat a coincident set");

    vco_clear_a: assert property ((int_en && clr[PEL_BIT_VCO] && !hit[PEL_BIT_VCO]) |=> !event_reg[PEL_BIT_VCO])
        else $error("VCO flag not cleared by zero write");

    ret_clear_a: assert property ((int_en && clr[PEL_BIT_RETURN] && !hit[PEL_BIT_RETURN]) |=> !event_reg[PEL_BIT_RETURN])
        else $error("return flag not cleared by zero write");

    irq_disabled_a: assert property (!int_en |=> !irq_o)
        else $error("interrupt raised while disabled");

    live_tracks_a: assert property (1'b1 |=> (live_o == $past(live_now)))
        else $error("live status lags sources");

    or_suppress_a: assert property ((!and_mode && ((event_reg & ~suppress_reg & PEL_EVENT_BITS) == 8'h00)) |=> !irq_o)
        else $error("suppressed flag raised interrupt");

    or_any_a: assert property ((int_en && !and_mode && event_reg[PEL_BIT_RETURN] && !suppress_reg[PEL_BIT_RETURN]) |=> irq_o)
        else $error("OR mode missed an active flag");

    and_all_a: assert property ((and_mode && (((event_reg | suppress_reg) & PEL_EVENT_BITS) != PEL_EVENT_BITS)) |=> !irq_o)
        else $error("AND mode fired with a flag idle");

    miss_over_unl_a: assert property (sync2_reg[2] |-> (!live_now[PEL_BIT_UNLOCKED] ##1 !live_o[PEL_BIT_UNLOCKED]))
        else $error("unlocked shown beside reference missing");

    edge_once_a: assert property (hit[PEL_BIT_VCO] |=> !hit[PEL_BIT_VCO])
        else $error("one transition hit twice");

    // Remaining edge shapes, so every source is checked on both selects
    sequence unl_fall_s;
        live_now[PEL_BIT_UNLOCKED] ##1 (!live_now[PEL_BIT_UNLOCKED] && !edge_sel_reg[PEL_BIT_UNLOCKED] && int_en);
    endsequence

    sequence miss_rise_s;
        !live_now[PEL_BIT_MISSING] ##1 (live_now[PEL_BIT_MISSING] && edge_sel_reg[PEL_BIT_MISSING] && int_en);
    endsequence

    sequence vco_rise_s;
        !live_now[PEL_BIT_VCO] ##1 (live_now[PEL_BIT_VCO] && edge_sel_reg[PEL_BIT_VCO] && int_en);
    endsequence

    sequence vco_fall_s;
        live_now[PEL_BIT_VCO] ##1 (!live_now[PEL_BIT_VCO] && !edge_sel_reg[PEL_BIT_VCO] && int_en);
    endsequence

    sequence ret_rise_s;
        !live_now[PEL_BIT_RETURN] ##1 (live_now[PEL_BIT_RETURN] && edge_sel_reg[PEL_BIT_RETURN] && int_en);
    endsequence

    sequence ret_fall_s;
        live_now[PEL_BIT_RETURN] ##1 (!live_now[PEL_BIT_RETURN] && !edge_sel_reg[PEL_BIT_RETURN] && int_en);
    endsequence

    unl_fall_set_a: assert property (unl_fall_s |=> event_reg[PEL_BIT_UNLOCKED])
        else $error("unlocked falling edge did not set its flag");

    miss_rise_set_a: assert property (miss_rise_s |=> event_reg[PEL_BIT_MISSING])
        else $error("missing rising edge did not set its flag");

    vco_rise_set_a: assert property (vco_rise_s |=> event_reg[PEL_BIT_VCO])
        else $error("VCO rising edge did not set its flag");

    vco_fall_set_a: assert property (vco_fall_s |=> event_reg[PEL_BIT_VCO])
        else $error("VCO falling edge did not set its flag");

    ret_rise_set_a: assert property (ret_rise_s |=> event_reg[PEL_BIT_RETURN])
        else $error("return rising edge did not set its flag");

    ret_fall_set_a: assert property (ret_fall_s |=> event_reg[PEL_BIT_RETURN])
        else $error("return falling edge did not set its flag");

    // The edge not selected never reaches a flag
    unl_wrong_edge_a: assert property ((edge_sel_reg[PEL_BIT_UNLOCKED] && fall[PEL_BIT_UNLOCKED]) |-> !hit[PEL_BIT_UNLOCKED])
        else $error("unlocked falling edge hit while rising selected");

    miss_wrong_edge_a: assert property ((!edge_sel_reg[PEL_BIT_MISSING] && rise[PEL_BIT_MISSING]) |-> !hit[PEL_BIT_MISSING])
        else $error("missing rising edge hit while falling selected");

    vco_rise_wrong_a: assert property ((!edge_sel_reg[PEL_BIT_VCO] && rise[PEL_BIT_VCO]) |-> !hit[PEL_BIT_VCO])
        else $error("VCO rising edge hit while falling selected");

    ret_rise_wrong_a: assert property ((edge_sel_reg[PEL_BIT_RETURN] && fall[PEL_BIT_RETURN]) |-> !hit[PEL_BIT_RETURN])
        else $error("return falling edge hit while rising selected");

    // Flags stay set until software clears them
    unl_sticky_a: assert property ((event_reg[PEL_BIT_UNLOCKED] && !clr[PEL_BIT_UNLOCKED]) |=> event_reg[PEL_BIT_UNLOCKED])
        else $error("unlocked flag dropped without a clear");

    miss_sticky_a: assert property ((event_reg[PEL_BIT_MISSING] && !clr[PEL_BIT_MISSING]) |=> event_reg[PEL_BIT_MISSING])
        else $error("missing flag dropped without a clear");

    ret_sticky_a: assert property ((event_reg[PEL_BIT_RETURN] && !clr[PEL_BIT_RETURN]) |=> event_reg[PEL_BIT_RETURN])
        else $error("return flag dropped without a clear");

    // A steady level alone never sets a flag
    no_edge_hold_a: assert property ((!hit[PEL_BIT_VCO] && !event_reg[PEL_BIT_VCO]) |=> !event_reg[PEL_BIT_VCO])
        else $error("VCO flag set without an edge");

    // Clearing writes, and a set that meets a clear in one cycle
    miss_clear_a: assert property ((int_en && clr[PEL_BIT_MISSING] && !hit[PEL_BIT_MISSING]) |=> !event_reg[PEL_BIT_MISSING])
        else $error("missing flag not cleared by zero write");

    unl_beats_a: assert property ((int_en && hit[PEL_BIT_UNLOCKED] && clr[PEL_BIT_UNLOCKED]) |=> event_reg[PEL_BIT_UNLOCKED])
        else $error("clear beat a coincident unlocked set");

    vco_beats_a: assert property ((int_en && hit[PEL_BIT_VCO] && clr[PEL_BIT_VCO]) |=> event_reg[PEL_BIT_VCO])
        else $error("clear beat a coincident VCO set");

    ret_beats_a: assert property ((int_en && hit[PEL_BIT_RETURN] && clr[PEL_BIT_RETURN]) |=> event_reg[PEL_BIT_RETURN])
        else $error("clear beat a coincident return set");

    // A lone suppressed flag keeps the interrupt low
    unl_suppress_a: assert property ((!and_mode && suppress_reg[PEL_BIT_UNLOCKED] && ((event_reg & PEL_EVENT_BITS) == 8'h80)) |=> !irq_o)
        else $error("suppressed unlocked flag raised interrupt");

    miss_suppress_a: assert property ((!and_mode && suppress_reg[PEL_BIT_MISSING] && ((event_reg & PEL_EVENT_BITS) == 8'h40)) |=> !irq_o)
        else $error("suppressed missing flag raised interrupt");

    vco_suppress_a: assert property ((!and_mode && suppress_reg[PEL_BIT_VCO] && ((event_reg & PEL_EVENT_BITS) == 8'h20)) |=> !irq_o)
        else $error("suppressed VCO flag raised interrupt");

    ret_suppress_a: assert property ((!and_mode && suppress_reg[PEL_BIT_RETURN] && ((event_reg & PEL_EVENT_BITS) == 8'h02)) |=> !irq_o)
        else $error("suppressed return flag raised interrupt");

    // Both combine modes must fire when their condition holds
    or_fire_a: assert property ((int_en && !and_mode && (active != 8'h00)) |=> irq_o)
        else $error("OR mode missed an unsuppressed flag");

    and_fire_a: assert property ((int_en && and_mode && all_act) |=> irq_o)
        else $error("AND mode missed a full set of flags");

    // Edge detection and precedence in the live view
    hit_change_a: assert property (hit[PEL_BIT_UNLOCKED] |-> (live_now[PEL_BIT_UNLOCKED] != prev_reg[PEL_BIT_UNLOCKED]))
        else $error("unlocked hit without a transition");

    live_no_unl_a: assert property (live_o[PEL_BIT_MISSING] |-> !live_o[PEL_BIT_UNLOCKED])
        else $error("live status shows unlocked beside missing");

    // Reserved event and control bits must never read back as set
    ev_reserved_a: assert property ((event_reg & ~PEL_EVENT_BITS) == 8'h00)
        else $error("reserved event bit set");

    ctl_reserved_a: assert property ((control_reg & ~PEL_CTL_BITS) == 8'h00)
        else $error("reserved control bit set");

    // Writes land on the taking edge
    wr_suppress_a: assert property (wr_suppress |=> (suppress_reg == $past(bus_req_i.wdata)))
        else $error("suppress write did not land");

    wr_edge_a: assert property (wr_edge_sel |=> (edge_sel_reg == $past(bus_req_i.wdata)))
        else $error("edge select write did not land");

    wr_ctl_a: assert property (wr_control |=> (control_reg == ($past(bus_req_i.wdata) & PEL_CTL_BITS)))
        else $error("control write did not land");

    // Reads return the value that stood at the strobe
    rd_event_a: assert property ((bus_req_i.rd && (bus_req_i.addr == PEL_OFS_EVENT)) |=> (rd_data_o == $past(event_reg)))
        else $error("event read returned a stale value");

    rd_live_a: assert property ((bus_req_i.rd && (bus_req_i.addr == PEL_OFS_LIVE)) |=> (rd_data_o == $past(prev_reg)))
        else $error("live read returned a stale value");

    rd_one_cycle_a: assert property (!bus_req_i.rd |=> (rd_data_o == 8'h00))
        else $error("read data stood outside its cycle");

endmodule : pel_top

`default_nettype wire

//--- shared/pel_pkg.sv
// Package of offsets, field positions, reset values and carrier types for the PLL event latch
package pel_pkg;

    // Register bus widths
    localparam int PEL_AW = 5;
    localparam int PEL_DW = 8;

    // Register offsets, byte addresses on the plain port
    localparam logic [4:0] PEL_OFS_LIVE = 5'h0D;
    localparam logic [4:0] PEL_OFS_SUPPRESS = 5'h0E;
    localparam logic [4:0] PEL_OFS_EDGE_SEL = 5'h0F;
    localparam logic [4:0] PEL_OFS_EVENT = 5'h10;
    localparam logic [4:0] PEL_OFS_CONTROL = 5'h11;

    // Event field positions, shared by every event register
    localparam int PEL_BIT_UNLOCKED = 7;
    localparam int PEL_BIT_MISSING = 6;
    localparam int PEL_BIT_VCO = 5;
    localparam int PEL_BIT_RETURN = 1;
    localparam logic [7:0] PEL_EVENT_BITS = 8'hE2;

    // Control field positions
    localparam int PEL_CTL_ENABLE_BIT = 0;
    localparam int PEL_CTL_AND_BIT = 1;
    localparam logic [7:0] PEL_CTL_BITS = 8'h03;

    // Reset values
    localparam logic [7:0] PEL_RST_SUPPRESS = 8'h00;
    localparam logic [7:0] PEL_RST_EDGE_SEL = 8'h00;
    localparam logic [7:0] PEL_RST_EVENT = 8'h00;
    localparam logic [7:0] PEL_RST_CONTROL = 8'h00;
    localparam logic [7:0] PEL_RST_LIVE = 8'h00;
    localparam logic [3:0] PEL_RST_SRC = 4'h0;

    // One bus request, as the master drives it
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } pel_bus_req_t;

    // The four internal event sources
    typedef struct packed {
        logic pll_unlocked_source;
        logic reference_missing_source;
        logic vco_tuning_source;
        logic reference_return_source;
    } pel_src_t;

endpackage : pel_pkg

//--- verif/pel_top_test.sv
// Self-checking bench for the PLL event interrupt latch
`timescale 1ns/1ns
`default_nettype none

module pel_top_test;
    import pel_pkg::*;

    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    pel_bus_req_t bus_req_i = '0;
    pel_src_t src_i = '0;
    logic [7:0] rd_data_o;
    logic irq_o;
    logic [7:0] live_o;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 32'h8A8516B4;
    logic [7:0] exp_q[$];
    logic rd_taken = 1'b0;
    // Event bit of each source, struct order from the top bit down
    logic [7:0] ev_bit[4] = '{8'h80, 8'h40, 8'h20, 8'h02};

    pel_top DUT (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .bus_req_i(bus_req_i),
        .src_i(src_i),
        .rd_data_o(rd_data_o),
        .irq_o(irq_o),
        .live_o(live_o)
    );

    // 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;

    // Single comparison point, four-state exact
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : chk

    // Bus requests are held across one edge; release only through idle
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        bus_req_i <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_i);
    endtask : wr_reg

    task automatic rd_reg(input logic [4:0] a, input logic [7:0] want);
        bus_req_i <= '{1'b0, 1'b1, a, 8'h00};
        exp_q.push_back(want);
        @(posedge ref_clk_i);
    endtask : rd_reg

    // Ends just past the edge so outputs have settled before any look
    task automatic idle(input int n);
        bus_req_i <= '0;
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : idle

    // Read data stands only in the cycle after the taking edge; judged mid-cycle
    always @(posedge ref_clk_i) rd_taken <= bus_req_i.rd & reset_n_i;
    always @(negedge ref_clk_i) begin
        if (rd_taken) begin
            if (exp_q.size() == 0) begin
                chk("unexpected read", rd_data_o, 8'hXX);
            end else begin
                chk("read data", rd_data_o, exp_q.pop_front());
            end
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        bad_count++;
        conclude();
    end

    initial begin
        logic [7:0] v;
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        idle(1);
        // Reset values, unmapped read
        rd_reg(PEL_OFS_LIVE, PEL_RST_LIVE);
        rd_reg(PEL_OFS_SUPPRESS, PEL_RST_SUPPRESS);
        rd_reg(PEL_OFS_EDGE_SEL, PEL_RST_EDGE_SEL);
        rd_reg(PEL_OFS_EVENT, PEL_RST_EVENT);
        rd_reg(PEL_OFS_CONTROL, PEL_RST_CONTROL);
        rd_reg(5'h1F, 8'h00);
        idle(2);
        $display("test reset values done");
        // Random readback; read-only and unmapped writes ignored
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr_reg(PEL_OFS_SUPPRESS, v);
            rd_reg(PEL_OFS_SUPPRESS, v);
            v = $random(seed);
            wr_reg(PEL_OFS_EDGE_SEL, v);
            rd_reg(PEL_OFS_EDGE_SEL, v);
        end
        wr_reg(PEL_OFS_LIVE, 8'hFF);
        wr_reg(5'h1F, 8'hFF);
        wr_reg(PEL_OFS_CONTROL, 8'hFF);
        rd_reg(PEL_OFS_CONTROL, PEL_CTL_BITS);
        rd_reg(PEL_OFS_LIVE, 8'h00);
        wr_reg(PEL_OFS_CONTROL, 8'h01);
        wr_reg(PEL_OFS_SUPPRESS, 8'h00);
        idle(2);
        $display("test register access done");
        // Each source, both edge choices: set, hold, suppress, clear
        for (int s = 0; s < 4; s++) begin
            for (int pol = 0; pol < 2; pol++) begin
                wr_reg(PEL_OFS_EDGE_SEL, pol ? ev_bit[s] : 8'h00);
                src_i[3-s] <= 1'b1;
                idle(6);
                chk("live", live_o, ev_bit[s]);
                rd_reg(PEL_OFS_EVENT, pol ? ev_bit[s] : 8'h00);
                src_i[3-s] <= 1'b0;
                idle(6);
                rd_reg(PEL_OFS_EVENT, ev_bit[s]);
                idle(1);
                chk("irq", irq_o, 8'h01);
                wr_reg(PEL_OFS_SUPPRESS, ev_bit[s]);
                idle(3);
                chk("irq suppressed", irq_o, 8'h00);
                wr_reg(PEL_OFS_SUPPRESS, 8'h00);
                wr_reg(PEL_OFS_EVENT, ~ev_bit[s]);
                idle(3);
                chk("irq cleared", irq_o, 8'h00);
                rd_reg(PEL_OFS_EVENT, 8'h00);
                idle(1);
            end
        end
        $display("test edges and flags done");
        // Global enable off: flags frozen, edges lost, interrupt held low
        wr_reg(PEL_OFS_EDGE_SEL, 8'hA0);
        src_i.pll_unlocked_source <= 1'b1;
        idle(6);
        wr_reg(PEL_OFS_CONTROL, 8'h00);
        wr_reg(PEL_OFS_EVENT, 8'h00);
        src_i.vco_tuning_source <= 1'b1;
        idle(6);
        chk("irq disabled", irq_o, 8'h00);
        chk("live disabled", live_o, 8'hA0);
        rd_reg(PEL_OFS_EVENT, 8'h80);
        wr_reg(PEL_OFS_CONTROL, 8'h01);
        idle(6);
        rd_reg(PEL_OFS_EVENT, 8'h80);
        idle(1);
        chk("irq enabled", irq_o, 8'h01);
        $display("test enable done");
        // AND combine needs every unsuppressed flag
        wr_reg(PEL_OFS_CONTROL, 8'h03);
        idle(3);
        chk("irq and", irq_o, 8'h00);
        wr_reg(PEL_OFS_SUPPRESS, 8'h7F);
        idle(3);
        chk("irq and one", irq_o, 8'h01);
        wr_reg(PEL_OFS_SUPPRESS, 8'hFF);
        idle(3);
        chk("irq and none", irq_o, 8'h00);
        // Lost reference hides the unlock; its edge meets a clearing write in one cycle
        wr_reg(PEL_OFS_CONTROL, 8'h01);
        wr_reg(PEL_OFS_SUPPRESS, 8'h00);
        wr_reg(PEL_OFS_EDGE_SEL, 8'h40);
        src_i.reference_missing_source <= 1'b1;
        idle(2);
        wr_reg(PEL_OFS_EVENT, 8'h00);
        idle(6);
        chk("live missing", live_o, 8'h60);
        rd_reg(PEL_OFS_EVENT, 8'hC0);
        idle(2);
        $display("test combine and precedence done");
        conclude();
    end
endmodule : pel_top_test

`default_nettype wire
